//--- core/ptm_core.v
// periodic timer with pwm, single pulse and capture modes behind apb
`timescale 1ns/10ps
`include "ptm_map.vh"
// Notes on behaviour
// - pwm period is 1024 clocks for period value 0, else the period value.
// - compare a at or above the period gives full duty.
// - pwm counter keeps running while the pin is forced low or high.
// - clear select ignored in pwm; a counter clear starts a new period.
// - run bit rising starts counter and pulse leading edge.
// - external clock pin rising edge sets run bit in single pulse mode.
// - pulse ends on run clear or compare a match, which clears run.
// - compare a match in single pulse sets match a flag.
// - single pulse counter zeroes only on run rising; period ignored.
// - capture mode is 01; source select picks io pin or ext clock pin.
// - action picks rising, falling or both edges; 11 disables capture.
// - capture counter starts on run rising, free-runs until run falls.
// - active capture edge copies counter to compare a and sets flag.
// - capture period match zeroes counter and sets flag; zero means full count.
// - capture pulses narrower than two timer clocks may be missed.
// - latch on the first timer clock after the synchronised edge; flag one timer clock later.
// - capture ignores clear select and initial level; invert still sets the pin level, but output enable stays low.
// - pwm output is mode 10 with action 10.
// - initial level picks pwm polarity; invert flips the pin too.
// - counter and compare values are 10 bits wide.
module ptm_core #(
    parameter CW = 10
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire timer_io_pin_in,
    output reg timer_io_pin_out,
    output reg timer_io_pin_oe,
    input wire ext_clock_pin,
    output reg irq_match_a,
    output reg irq_match_p
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [7:0] ctrl0_reg;
    reg [7:0] ctrl1_reg;
    reg [CW-1:0] cnt_reg;
    reg [CW-1:0] cnt_next;
    reg [CW-1:0] cmpa_reg;
    reg [CW-1:0] perd_reg;
    reg match_a_flag;
    reg match_p_flag;
    reg run_q;
    reg io_s1;
    reg io_s2;
    reg io_s3;
    reg ck_s1;
    reg ck_s2;
    reg ck_s3;
    reg cap_pend;
    reg [CW-1:0] cap_val;
    reg af_pend;
    reg out_lvl;
    wire tick;
    wire counter_run;
    wire [1:0] mode_sel;
    wire [1:0] out_act;
    wire wr_en;
    wire rd_en;
    wire run_rise;
    wire match_a;
    wire match_p;
    wire cap_src;
    wire cap_prev;
    wire cap_edge;
    wire ck_rise;
    wire pwm_active;
    wire pwm_level;
    reg run_set;
    reg run_clr;
    reg a_set;
    reg p_set;

    // field decode of the control registers
    assign counter_run = ctrl0_reg[`PTM_C0_RUN];
    assign mode_sel = {ctrl1_reg[`PTM_C1_MODE_HI], ctrl1_reg[`PTM_C1_MODE_LO]};
    assign out_act = {ctrl1_reg[`PTM_C1_IO_HI], ctrl1_reg[`PTM_C1_IO_LO]};
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // a period value of zero stands for the full 2^cw count
    function is_period_end;
        input [CW-1:0] cnt;
        input [CW-1:0] per;
        begin
            is_period_end = (per == {CW{1'b0}}) ? (cnt == {CW{1'b1}})
                                                : (cnt == per - {{(CW-1){1'b0}}, 1'b1});
        end
    endfunction

    // active edge detect for the capture input
    function edge_hit;
        input [1:0] act;
        input prev;
        input cur;
        begin
            case (act)
                `PTM_IO_RISE: edge_hit = ~prev & cur;
                `PTM_IO_FALL: edge_hit = prev & ~cur;
                `PTM_IO_BOTH: edge_hit = prev ^ cur;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // timer clock enable
    // ----------------------------------------
    ptm_prescaler #(
        .SEL_W(3)
    ) u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .div_sel(ctrl0_reg[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO]),
        .clear(run_rise),
        .tick(tick)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two stages then a third for edge history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_s1 <= 1'b0;
            io_s2 <= 1'b0;
            io_s3 <= 1'b0;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
        end else begin
            io_s1 <= timer_io_pin_in;
            io_s2 <= io_s1;
            io_s3 <= io_s2;
            ck_s1 <= ext_clock_pin;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
        end
    end

    assign ck_rise = ck_s2 & ~ck_s3;
    assign cap_src = ctrl1_reg[`PTM_C1_CKS] ? ck_s2 : io_s2;
    assign cap_prev = ctrl1_reg[`PTM_C1_CKS] ? ck_s3 : io_s3;
    assign cap_edge = (mode_sel == `PTM_MODE_CAP) && counter_run &&
                      edge_hit(out_act, cap_prev, cap_src);

    // ----------------------------------------
    // counter and comparators
    // ----------------------------------------
    assign run_rise = counter_run & ~run_q;
    assign match_a = tick && counter_run && (cnt_reg == cmpa_reg);
    assign match_p = tick && counter_run && is_period_end(cnt_reg, perd_reg);

    // next count per mode; clear select is honoured only outside pwm/pulse/capture
    always @* begin
        cnt_next = cnt_reg;
        if (run_rise) begin
            cnt_next = {CW{1'b0}};
        end else if (tick && counter_run) begin
            cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            case (mode_sel)
                `PTM_MODE_PWM: begin
                    if (out_act != `PTM_IO_PULSE && match_p) begin
                        cnt_next = {CW{1'b0}};
                    end
                end
                `PTM_MODE_CAP: begin
                    if (match_p) begin
                        cnt_next = {CW{1'b0}};
                    end
                end
                default: begin
                    if (ctrl1_reg[`PTM_C1_CCLR] ? match_a : match_p) begin
                        cnt_next = {CW{1'b0}};
                    end
                end
            endcase
        end
    end

    // hardware run-bit sets and clears plus flag events
    always @* begin
        run_set = 1'b0;
        run_clr = 1'b0;
        a_set = 1'b0;
        p_set = 1'b0;
        if (mode_sel == `PTM_MODE_PWM && out_act == `PTM_IO_PULSE) begin
            run_set = ck_rise & ~counter_run;
            run_clr = match_a;
            a_set = match_a;
        end else if (mode_sel == `PTM_MODE_CAP) begin
            a_set = af_pend & tick;
            p_set = match_p;
        end else begin
            a_set = match_a;
            p_set = match_p & ~(mode_sel != `PTM_MODE_PWM && ctrl1_reg[`PTM_C1_CCLR]);
        end
    end

    // counter, capture pipeline and run history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= `PTM_VAL_RST;
            run_q <= 1'b0;
            cap_pend <= 1'b0;
            cap_val <= `PTM_VAL_RST;
            af_pend <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_q <= counter_run;
            if (cap_edge) begin
                cap_pend <= 1'b1;
                cap_val <= cnt_reg;
            end else if (cap_pend && tick) begin
                cap_pend <= 1'b0;
            end
            if (cap_pend && tick) begin
                af_pend <= 1'b1;
            end else if (a_set || mode_sel != `PTM_MODE_CAP) begin
                af_pend <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // apb register file
    // ----------------------------------------
    // writes, hardware sets win over software clears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= `PTM_CTRL_RST;
            ctrl1_reg <= `PTM_CTRL_RST;
            cmpa_reg <= `PTM_VAL_RST;
            perd_reg <= `PTM_VAL_RST;
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            if (wr_en && paddr == `PTM_CTRL0_OFS) begin
                ctrl0_reg <= pwdata[7:0];
            end
            if (run_set) begin
                ctrl0_reg[`PTM_C0_RUN] <= 1'b1;
            end else if (run_clr) begin
                ctrl0_reg[`PTM_C0_RUN] <= 1'b0;
            end
            if (wr_en && paddr == `PTM_CTRL1_OFS) begin
                ctrl1_reg <= pwdata[7:0];
            end
            if (cap_pend && tick) begin
                cmpa_reg <= cap_val;
            end else if (wr_en && paddr == `PTM_CMPA_OFS) begin
                cmpa_reg <= pwdata[CW-1:0];
            end
            if (wr_en && paddr == `PTM_PERD_OFS) begin
                perd_reg <= pwdata[CW-1:0];
            end
            if (a_set) begin
                match_a_flag <= 1'b1;
            end else if (wr_en && paddr == `PTM_FLAG_OFS && pwdata[`PTM_FL_AF]) begin
                match_a_flag <= 1'b0;
            end
            if (p_set) begin
                match_p_flag <= 1'b1;
            end else if (wr_en && paddr == `PTM_FLAG_OFS && pwdata[`PTM_FL_PF]) begin
                match_p_flag <= 1'b0;
            end
        end
    end

    // read data, ready and error, one wait-free access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `PTM_FLAG_OFS || paddr[1:0] != 2'b00);
            if (rd_en) begin
                case (paddr)
                    `PTM_CTRL0_OFS: prdata <= {24'h00_0000, ctrl0_reg};
                    `PTM_CTRL1_OFS: prdata <= {24'h00_0000, ctrl1_reg};
                    `PTM_CNT_OFS: prdata <= {{(32-CW){1'b0}}, cnt_reg};
                    `PTM_CMPA_OFS: prdata <= {{(32-CW){1'b0}}, cmpa_reg};
                    `PTM_PERD_OFS: prdata <= {{(32-CW){1'b0}}, perd_reg};
                    `PTM_FLAG_OFS: prdata <= {30'h0000_0000, match_p_flag, match_a_flag};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // output pin
    // ----------------------------------------
    // full duty when compare a reaches the period
    assign pwm_active = (perd_reg != {CW{1'b0}} && cmpa_reg >= perd_reg)
                        ? 1'b1 : (cnt_reg < cmpa_reg);
    assign pwm_level = ctrl1_reg[`PTM_C1_OC] ? pwm_active : ~pwm_active;

    // pulse follows the run bit; pin level per mode and action
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_lvl <= 1'b0;
            timer_io_pin_out <= 1'b0;
            timer_io_pin_oe <= 1'b0;
            irq_match_a <= 1'b0;
            irq_match_p <= 1'b0;
        end else begin
            out_lvl <= 1'b0;
            if (mode_sel == `PTM_MODE_PWM) begin
                case (out_act)
                    `PTM_IO_LOW: out_lvl <= 1'b0;
                    `PTM_IO_HIGH: out_lvl <= 1'b1;
                    `PTM_IO_PWM: out_lvl <= counter_run & pwm_level;
                    default: out_lvl <= counter_run & ~run_clr;
                endcase
            end
            timer_io_pin_out <= out_lvl ^ ctrl1_reg[`PTM_C1_POL];
            timer_io_pin_oe <= (mode_sel == `PTM_MODE_PWM);
            irq_match_a <= match_a_flag;
            irq_match_p <= match_p_flag;
        end
    end
endmodule

//--- common/ptm_map.vh
// register offsets, field positions, reset values and timing counts of the periodic timer
`ifndef PTM_MAP_VH
`define PTM_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PTM_CTRL0_OFS 12'h000
`define PTM_CTRL1_OFS 12'h004
`define PTM_CNT_OFS 12'h008
`define PTM_CMPA_OFS 12'h00C
`define PTM_PERD_OFS 12'h010
`define PTM_FLAG_OFS 12'h014
// ----------------------------------------
// control register 0 fields
// ----------------------------------------
`define PTM_C0_RUN 3
`define PTM_C0_CKSEL_LO 0
`define PTM_C0_CKSEL_HI 2
// ----------------------------------------
// control register 1 fields
// ----------------------------------------
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_IO_HI 5
`define PTM_C1_IO_LO 4
`define PTM_C1_OC 3
`define PTM_C1_POL 2
`define PTM_C1_CKS 1
`define PTM_C1_CCLR 0
// ----------------------------------------
// flag register fields
// ----------------------------------------
`define PTM_FL_AF 0
`define PTM_FL_PF 1
// ----------------------------------------
// modes and output actions
// ----------------------------------------
`define PTM_MODE_CMP 2'b00
`define PTM_MODE_CAP 2'b01
`define PTM_MODE_PWM 2'b10
`define PTM_MODE_TMR 2'b11
`define PTM_IO_RISE 2'b00
`define PTM_IO_FALL 2'b01
`define PTM_IO_BOTH 2'b10
`define PTM_IO_NONE 2'b11
`define PTM_IO_PWM 2'b10
`define PTM_IO_LOW 2'b00
`define PTM_IO_HIGH 2'b01
`define PTM_IO_PULSE 2'b11
// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define PTM_CNT_W 10
`define PTM_CTRL_RST 8'h00
`define PTM_VAL_RST 10'h000
`define PTM_CAP_MIN_TCLK 2
`endif

//--- core/ptm_prescaler.v
// timer clock enable divider for the periodic timer
`timescale 1ns/10ps
module ptm_prescaler #(
    parameter SEL_W = 3
) (
    input wire pclk,
    input wire presetn,
    input wire [SEL_W-1:0] div_sel,
    input wire clear,
    output reg tick
);
    reg [7:0] div_reg;
    reg [7:0] div_next;
    reg hit;

    // ----------------------------------------
    // divide pclk by 2^div_sel
    // ----------------------------------------
    // terminal count of the running divider
    always @* begin
        div_next = div_reg + 8'h01;
        hit = ((div_reg | ~((8'h01 << div_sel) - 8'h01)) == 8'hFF);
        if (hit || clear) begin
            div_next = 8'h00;
        end
    end

    // divider register and enable pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
            tick <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick <= hit & ~clear;
        end
    end
endmodule

//--- bench/ptm_core_sva.sv
// assertion checker for the periodic timer bus and pin behaviour
`timescale 1ns/10ps
`include "ptm_map.vh"
module ptm_core_sva #(
    parameter CW = 10
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire timer_io_pin_in,
    input wire timer_io_pin_out,
    input wire timer_io_pin_oe,
    input wire ext_clock_pin,
    input wire irq_match_a,
    input wire irq_match_p
);
    reg [7:0] ctrl0_reg;
    reg [7:0] ctrl1_reg;
    reg [9:0] cmpa_reg;
    reg [9:0] per_reg;
    reg [10:0] quiet_reg;
    wire wr_done = psel && penable && pready && pwrite;
    wire clr_a = wr_done && (paddr == `PTM_FLAG_OFS) && pwdata[0];
    wire act_lvl = ctrl1_reg[3] ^ ctrl1_reg[2];
    wire pwm_on = (ctrl1_reg[7:4] == 4'hA) && ctrl0_reg[3] && (ctrl0_reg[2:0] == 3'h0)
        && (quiet_reg >= 11'h44C);
    // ----------------------------------------
    // mirror of software settings and a settle counter since the last write
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= 8'h00;
            ctrl1_reg <= 8'h00;
            cmpa_reg <= 10'h000;
            per_reg <= 10'h000;
            quiet_reg <= 11'h000;
        end else if (wr_done) begin
            quiet_reg <= 11'h000;
            if (paddr == `PTM_CTRL0_OFS) ctrl0_reg <= pwdata[7:0];
            if (paddr == `PTM_CTRL1_OFS) ctrl1_reg <= pwdata[7:0];
            if (paddr == `PTM_CMPA_OFS) cmpa_reg <= pwdata[9:0];
            if (paddr == `PTM_PERD_OFS) per_reg <= pwdata[9:0];
        end else if (quiet_reg != 11'h7FF) begin
            quiet_reg <= quiet_reg + 11'h001;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_setup;
        s_setup ##0 ((paddr > `PTM_FLAG_OFS) || (paddr[1:0] != 2'b00));
    endsequence
    AST_PREADY_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready) else $error("no answer after setup");
    AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        s_bad_setup |=> pready && pslverr) else $error("unmapped access not refused");
    AST_ERR_READ: assert property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("refused read data");
    AST_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && !pslverr && paddr >= `PTM_CNT_OFS && paddr <= `PTM_PERD_OFS
        |-> prdata[31:10] == 22'h00_0000) else $error("value wider than ten bits");
    AST_OE_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        quiet_reg >= 11'h004 |-> timer_io_pin_oe == (ctrl1_reg[7:6] == `PTM_MODE_PWM))
        else $error("output enable does not follow mode");
    AST_PWM_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_on && per_reg != 10'h000 && cmpa_reg >= per_reg |-> timer_io_pin_out == act_lvl)
        else $error("full duty not held");
    AST_PWM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_on && cmpa_reg == 10'h000 |-> (timer_io_pin_out == !act_lvl)[*2])
        else $error("zero duty shows active level");
    AST_IRQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(irq_match_a) |-> $past(clr_a) || $past(clr_a, 2))
        else $error("match a request dropped without clear");
endmodule
bind ptm_core ptm_core_sva #(.CW(CW)) ptm_core_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_io_pin_in(timer_io_pin_in), .timer_io_pin_out(timer_io_pin_out),
    .timer_io_pin_oe(timer_io_pin_oe), .ext_clock_pin(ext_clock_pin),
    .irq_match_a(irq_match_a), .irq_match_p(irq_match_p)
);

//--- bench/ptm_pin_model.sv
// external pulse source for the timer io pin and the external clock pin
`timescale 1ns/10ps
module ptm_pin_model #(
    parameter MIN_HOLD = 4
) (
    input wire pclk,
    output reg io_level,
    output reg ext_level
);
    // ----------------------------------------
    // both pins idle low
    // ----------------------------------------
    initial begin
        io_level = 1'b0;
        ext_level = 1'b0;
    end
    // change one pin after an edge and keep it for at least four bus clocks
    task set_pin(input logic which, input logic v);
        begin
            if (which) ext_level <= v;
            else io_level <= v;
            repeat (MIN_HOLD) @(posedge pclk);
        end
    endtask
endmodule

//--- bench/tb.sv
// self-checking testbench for the periodic timer
`timescale 1ns/10ps
`include "ptm_map.vh"
module tb;
    localparam [31:0] ONE = 32'h0000_0001;
    localparam [31:0] ZERO = 32'h0000_0000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, c1, c2;
    logic timer_io_pin_out, timer_io_pin_oe, irq_match_a, irq_match_p, io_in, ext_pin;
    integer errors, comparisons, i, h, w;
    ptm_core ptm_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_io_pin_in(io_in), .timer_io_pin_out(timer_io_pin_out),
        .timer_io_pin_oe(timer_io_pin_oe), .ext_clock_pin(ext_pin),
        .irq_match_a(irq_match_a), .irq_match_p(irq_match_p));
    ptm_pin_model ptm_pin_model_inst (.pclk(pclk), .io_level(io_in), .ext_level(ext_pin));
    always #12.5 pclk = ~pclk;
    // ----------------------------------------
    // verdict, comparison and bus tasks
    // ----------------------------------------
    task final_report;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr_en;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge pclk);
            end
            if (n == 50) begin
                errors = errors + 1;
                final_report;
            end
            rdv = prdata;
            erv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, ZERO);
            chk(rdv, exp);
        end
    endtask
    task count_high(input integer n);
        begin
            h = 0;
            repeat (n) begin
                @(posedge pclk);
                if (timer_io_pin_out === 1'b1) h = h + 1;
            end
        end
    endtask
    // program one pwm setting, let it settle, count high pin cycles in a window
    task pwm_run(input logic [9:0] per, input logic [9:0] a, input logic oc, input logic pol,
        input logic cclr, input integer win, input integer exp);
        begin
            wr(`PTM_CTRL0_OFS, ZERO);
            wr(`PTM_PERD_OFS, {22'h00_0000, per});
            wr(`PTM_CMPA_OFS, {22'h00_0000, a});
            wr(`PTM_CTRL1_OFS, {24'h00_0000, 4'b1010, oc, pol, 1'b0, cclr});
            wr(`PTM_CTRL0_OFS, 32'h0000_0008);
            repeat (1100) @(posedge pclk);
            count_high(win);
            chk(h, exp);
        end
    endtask
    // wait for the single pulse, then measure how long it stays up
    task pulse_width;
        integer n;
        begin
            n = 0;
            w = 0;
            while (timer_io_pin_out !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge pclk);
            end
            while (timer_io_pin_out === 1'b1 && w < 2000) begin
                w = w + 1;
                @(posedge pclk);
            end
            if (n == 50 || w == 2000) begin
                errors = errors + 1;
                final_report;
            end
            chk(w >= 20 && w <= 22, ONE);
            repeat (4) @(posedge pclk);
        end
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = ZERO;
        errors = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, ten-bit fields, read-only counter, refused address
        for (i = 0; i < 6; i = i + 1) rdchk(12'(4 * i), ZERO);
        wr(`PTM_CMPA_OFS, 32'hFFFF_FFFF);
        rdchk(`PTM_CMPA_OFS, 32'h0000_03FF);
        wr(`PTM_CNT_OFS, 32'h0000_0055);
        rdchk(`PTM_CNT_OFS, ZERO);
        apb(1'b0, 12'h018, ZERO);
        chk({erv, rdv[30:0]}, 32'h8000_0000);
        $display("test registers done");
        // pwm period, duty, full and zero duty, polarity, clear select ignored
        pwm_run(10'h008, 10'h003, 1'b1, 1'b0, 1'b1, 64, 24);
        chk(timer_io_pin_oe, ONE);
        pwm_run(10'h008, 10'h003, 1'b1, 1'b1, 1'b0, 64, 40);
        pwm_run(10'h008, 10'h003, 1'b0, 1'b0, 1'b0, 64, 40);
        pwm_run(10'h008, 10'h008, 1'b1, 1'b0, 1'b0, 64, 64);
        pwm_run(10'h008, 10'h000, 1'b1, 1'b0, 1'b0, 64, 0);
        pwm_run(10'h000, 10'h200, 1'b1, 1'b0, 1'b0, 2048, 1024);
        wr(`PTM_CTRL1_OFS, 32'h0000_0088);
        apb(1'b0, `PTM_CNT_OFS, ZERO);
        c1 = rdv;
        count_high(64);
        chk(h == 0 || h == 64, ONE);
        apb(1'b0, `PTM_CNT_OFS, ZERO);
        chk(rdv != c1, ONE);
        $display("test pwm done");
        // single pulse: period below compare a must not shorten it
        wr(`PTM_CTRL0_OFS, ZERO);
        wr(`PTM_FLAG_OFS, 32'h0000_0003);
        wr(`PTM_PERD_OFS, 32'h0000_0005);
        wr(`PTM_CMPA_OFS, 32'h0000_0014);
        wr(`PTM_CTRL1_OFS, 32'h0000_00B8);
        wr(`PTM_CTRL0_OFS, 32'h0000_0008);
        pulse_width;
        rdchk(`PTM_CTRL0_OFS, ZERO);
        chk(irq_match_a, ONE);
        wr(`PTM_FLAG_OFS, ONE);
        ptm_pin_model_inst.set_pin(1'b1, 1'b1);
        pulse_width;
        ptm_pin_model_inst.set_pin(1'b1, 1'b0);
        $display("test single pulse done");
        // capture from the external clock pin; timer clock stays the bus clock
        wr(`PTM_CTRL0_OFS, ZERO);
        wr(`PTM_PERD_OFS, ZERO);
        wr(`PTM_FLAG_OFS, 32'h0000_0003);
        wr(`PTM_CTRL1_OFS, 32'h0000_0042);
        wr(`PTM_CTRL0_OFS, 32'h0000_0008);
        repeat (100) @(posedge pclk);
        apb(1'b0, `PTM_CNT_OFS, ZERO);
        c1 = rdv;
        ptm_pin_model_inst.set_pin(1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        apb(1'b0, `PTM_CMPA_OFS, ZERO);
        c2 = (rdv - c1) & 32'h0000_03FF;
        chk(c2 >= 1 && c2 <= 10, ONE);
        chk(irq_match_a, ONE);
        wr(`PTM_FLAG_OFS, ONE);
        // every edge selection on the io pin, rising then falling
        for (i = 0; i < 4; i = i + 1) begin
            wr(`PTM_CTRL1_OFS, {24'h00_0000, 2'b01, i[1:0], 4'b0000});
            ptm_pin_model_inst.set_pin(1'b0, 1'b1);
            repeat (8) @(posedge pclk);
            chk(irq_match_a, i == 0 || i == 2);
            wr(`PTM_FLAG_OFS, ONE);
            ptm_pin_model_inst.set_pin(1'b0, 1'b0);
            repeat (8) @(posedge pclk);
            chk(irq_match_a, i == 1 || i == 2);
            wr(`PTM_FLAG_OFS, ONE);
        end
        apb(1'b0, `PTM_CNT_OFS, ZERO);
        c1 = rdv;
        apb(1'b0, `PTM_CNT_OFS, ZERO);
        chk(rdv != c1, ONE);
        // period match wraps the capture counter
        wr(`PTM_CTRL0_OFS, ZERO);
        wr(`PTM_PERD_OFS, 32'h0000_001E);
        wr(`PTM_FLAG_OFS, 32'h0000_0003);
        wr(`PTM_CTRL0_OFS, 32'h0000_0008);
        repeat (100) @(posedge pclk);
        chk(irq_match_p, ONE);
        apb(1'b0, `PTM_CNT_OFS, ZERO);
        chk(rdv < 32'h0000_001E, ONE);
        $display("test capture done");
        final_report;
    end
endmodule
